/* hw/rgbps_pkg.sv */
// Package of constants and types for the RGB pattern sequencer
package rgbps_pkg;

   // ==========================================================
   // Clock and time base
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_TIME_US = 100;
   localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_TIME_US;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_SEQUENCER_CONTROL = 8'h11;
   localparam logic [7:0] ADDR_GROUP1_CURRENT_SCALE = 8'h12;
   localparam logic [7:0] ADDR_GROUP2_CURRENT_SCALE = 8'h13;
   localparam logic [7:0] ADDR_SEQUENCER_STATUS = 8'h14;
   localparam logic [7:0] ADDR_COMMAND_BASE = 8'h40;
   localparam logic [3:0] ADDR_COMMAND_PAGE = 4'h4;

   // Reset values
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam logic [5:0] SCALE_RESET = 6'h00;
   localparam logic [7:0] COMMAND_RESET = 8'h00;

   // Control bit positions
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_REPEAT_BIT = 1;
   localparam int CTRL_CURVE_BIT = 0;

   // Command byte field positions (low bit of each field)
   localparam int FIRST_RED_LSB = 5;
   localparam int FIRST_GREEN_LSB = 2;
   localparam int FIRST_HOLD_HI_LSB = 0;
   localparam int SECOND_HOLD_LO_LSB = 6;
   localparam int SECOND_BLUE_LSB = 3;
   localparam int SECOND_RAMP_LSB = 0;

   // ==========================================================
   // Intensity curves, percent of full scale
   localparam logic [6:0] CURVE0_PCT [8] = '{7'h00, 7'h07, 7'h0e, 7'h15,
                                             7'h20, 7'h2e, 7'h47, 7'h64};
   localparam logic [6:0] CURVE1_PCT [8] = '{7'h00, 7'h01, 7'h02, 7'h04,
                                             7'h0a, 7'h15, 7'h2e, 7'h64};

   // Step hold and ramp times in ms
   localparam int HOLD_TIME_MS [16] = '{197, 393, 590, 786, 983, 1180, 1376, 1573,
                                        1769, 1966, 2163, 2359, 2556, 2753, 2949, 3146};
   localparam int RAMP_TIME_MS [8] = '{0, 55, 110, 221, 442, 885, 1770, 3539};
   localparam int TICKS_PER_MS = 1000 / TICK_TIME_US;

   // PWM frame: 100 percent times four quarter-scale steps
   localparam logic [8:0] PWM_PERIOD = 9'h190;
   localparam int SLOT_COUNT = 8;

   // ==========================================================
   // Types
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_LOAD = 3'b001,
      ST_RAMP = 3'b010,
      ST_HOLD = 3'b011,
      ST_DONE = 3'b100
   } rgbps_state_type;

   typedef struct packed
   {
      logic red;
      logic green;
      logic blue;
   } rgbps_rgb_type;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rgbps_reg_req_type;

endpackage : rgbps_pkg

/* hw/rgbps_pwm.sv */
// One PWM comparator stage with a registered output
`timescale 1ns/10ps
`default_nettype none

module rgbps_pwm #(
   parameter int WIDTH = 9
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Frame position and level
   input wire logic [WIDTH-1:0] count,
   input wire logic [WIDTH-1:0] duty,
   // Drive
   output logic pwm_out
);

   typedef struct packed
   {
      logic out;
   } rgbps_pwm_state_type;

   rgbps_pwm_state_type state;
   rgbps_pwm_state_type next_state;

   always_comb
   begin
      next_state = state;
      next_state.out = (count < duty);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pwm_out = state.out;

endmodule : rgbps_pwm

`default_nettype wire

/* hw/rgbps_seq.sv */
// RGB pattern sequencer: registers, command engine, ramps and PWM drives
`timescale 1ns/10ps
`default_nettype none

module rgbps_seq
   import rgbps_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port from the serial host interface
   input wire rgbps_reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   // LED drives
   output rgbps_rgb_type group1_drive,
   output rgbps_rgb_type group2_drive,
   output logic seq_busy
);

   // ==========================================================
   // State
   typedef struct packed
   {
      logic [2:0] ctrl;
      logic [5:0] scale1;
      logic [5:0] scale2;
      logic [15:0][7:0] cmd;
      logic [7:0] rdata;
      rgbps_state_type st;
      logic [2:0] slot;
      logic run_d;
      logic [11:0] tick_cnt;
      logic [15:0] timer;
      logic [15:0] ramp_len;
      logic [2:0][6:0] cur;
      logic [2:0][6:0] tgt;
      logic [2:0][6:0] dlt;
      logic [2:0] up;
      logic [2:0][15:0] acc;
      logic [8:0] pwm_cnt;
      logic [5:0][8:0] duty;
      logic busy;
   } rgbps_seq_state_type;

   rgbps_seq_state_type state;
   rgbps_seq_state_type next_state;

   logic tick;
   logic [7:0] first_byte;
   logic [7:0] second_byte;
   logic [3:0] hold_code;
   logic [2:0] ramp_code;
   logic [2:0][2:0] colour_code;
   logic [15:0] hold_ticks;
   logic [15:0] ramp_ticks;
   logic [15:0] acc_sum;
   logic [5:0] scale;

   assign tick = (state.tick_cnt == 12'(TICK_LEN - 1));
   assign first_byte = state.cmd[{state.slot, 1'b0}];
   assign second_byte = state.cmd[{state.slot, 1'b1}];
   assign hold_code = {first_byte[FIRST_HOLD_HI_LSB +: 2],
                       second_byte[SECOND_HOLD_LO_LSB +: 2]};
   assign ramp_code = second_byte[SECOND_RAMP_LSB +: 3];
   assign colour_code[0] = first_byte[FIRST_RED_LSB +: 3];
   assign colour_code[1] = first_byte[FIRST_GREEN_LSB +: 3];
   assign colour_code[2] = second_byte[SECOND_BLUE_LSB +: 3];
   assign hold_ticks = 16'(HOLD_TIME_MS[hold_code] * TICKS_PER_MS);
   assign ramp_ticks = 16'(RAMP_TIME_MS[ramp_code] * TICKS_PER_MS);

   // ==========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      acc_sum = '0;
      scale = '0;

      // Register writes and reads
      if (reg_req.wr)
      begin
         if (reg_req.addr == ADDR_SEQUENCER_CONTROL)
         begin
            next_state.ctrl = reg_req.wdata[2:0];
         end
         else if (reg_req.addr == ADDR_GROUP1_CURRENT_SCALE)
         begin
            next_state.scale1 = reg_req.wdata[5:0];
         end
         else if (reg_req.addr == ADDR_GROUP2_CURRENT_SCALE)
         begin
            next_state.scale2 = reg_req.wdata[5:0];
         end
         else if (reg_req.addr[7:4] == ADDR_COMMAND_PAGE)
         begin
            next_state.cmd[reg_req.addr[3:0]] = reg_req.wdata;
         end
      end
      if (reg_req.rd)
      begin
         if (reg_req.addr == ADDR_SEQUENCER_CONTROL)
         begin
            next_state.rdata = {5'h00, state.ctrl};
         end
         else if (reg_req.addr == ADDR_GROUP1_CURRENT_SCALE)
         begin
            next_state.rdata = {2'h0, state.scale1};
         end
         else if (reg_req.addr == ADDR_GROUP2_CURRENT_SCALE)
         begin
            next_state.rdata = {2'h0, state.scale2};
         end
         else if (reg_req.addr == ADDR_SEQUENCER_STATUS)
         begin
            next_state.rdata = {1'b0, state.st, state.busy, state.slot};
         end
         else if (reg_req.addr[7:4] == ADDR_COMMAND_PAGE)
         begin
            next_state.rdata = state.cmd[reg_req.addr[3:0]];
         end
         else
         begin
            next_state.rdata = 8'h00;
         end
      end

      // Time base, restarted at every command load
      next_state.tick_cnt = tick ? 12'h000 : state.tick_cnt + 12'h001;
      next_state.run_d = state.ctrl[CTRL_RUN_BIT];

      // Command engine
      if (!state.ctrl[CTRL_RUN_BIT])
      begin
         next_state.st = ST_IDLE;
         next_state.cur = '0;
         next_state.slot = 3'h0;
      end
      else
      begin
         unique case (state.st)
            ST_IDLE:
            begin
               if (!state.run_d)
               begin
                  next_state.st = ST_LOAD;
                  next_state.slot = 3'h0;
               end
            end
            ST_LOAD:
            begin
               next_state.tick_cnt = 12'h000;
               next_state.ramp_len = ramp_ticks;
               next_state.acc = '0;
               for (int c = 0; c < 3; c++)
               begin
                  // One curve choice for all three colours
                  next_state.tgt[c] = state.ctrl[CTRL_CURVE_BIT] ?
                                      CURVE1_PCT[colour_code[c]] :
                                      CURVE0_PCT[colour_code[c]];
                  next_state.up[c] = (next_state.tgt[c] > state.cur[c]);
                  next_state.dlt[c] = next_state.up[c] ?
                                      next_state.tgt[c] - state.cur[c] :
                                      state.cur[c] - next_state.tgt[c];
               end
               if (ramp_ticks == 16'h0000)
               begin
                  next_state.cur = next_state.tgt;
                  next_state.timer = hold_ticks;
                  next_state.st = ST_HOLD;
               end
               else
               begin
                  next_state.timer = ramp_ticks;
                  next_state.st = ST_RAMP;
               end
            end
            ST_RAMP:
            begin
               if (tick)
               begin
                  // Shortest ramp exceeds the largest step count, so one step per tick suffices
                  for (int c = 0; c < 3; c++)
                  begin
                     acc_sum = state.acc[c] + 16'(state.dlt[c]);
                     if (acc_sum >= state.ramp_len)
                     begin
                        next_state.acc[c] = acc_sum - state.ramp_len;
                        next_state.cur[c] = state.up[c] ? state.cur[c] + 7'h01 :
                                                          state.cur[c] - 7'h01;
                     end
                     else
                     begin
                        next_state.acc[c] = acc_sum;
                     end
                  end
                  next_state.timer = state.timer - 16'h0001;
                  if (state.timer == 16'h0001)
                  begin
                     next_state.cur = state.tgt;
                     next_state.timer = hold_ticks;
                     next_state.st = ST_HOLD;
                  end
               end
            end
            ST_HOLD:
            begin
               if (tick)
               begin
                  next_state.timer = state.timer - 16'h0001;
                  if (state.timer == 16'h0001)
                  begin
                     if (state.slot != 3'(SLOT_COUNT - 1))
                     begin
                        next_state.slot = state.slot + 3'h1;
                        next_state.st = ST_LOAD;
                     end
                     else if (state.ctrl[CTRL_REPEAT_BIT])
                     begin
                        next_state.slot = 3'h0;
                        next_state.st = ST_LOAD;
                     end
                     else
                     begin
                        next_state.st = ST_DONE;
                     end
                  end
               end
            end
            ST_DONE:
            begin
               next_state.st = ST_DONE;
            end
            default:
            begin
               next_state.st = ST_IDLE;
            end
         endcase
      end
      next_state.busy = (next_state.st != ST_IDLE) && (next_state.st != ST_DONE);

      // PWM frame and duty per channel
      next_state.pwm_cnt = (state.pwm_cnt == PWM_PERIOD - 9'h001) ?
                           9'h000 : state.pwm_cnt + 9'h001;
      for (int g = 0; g < 2; g++)
      begin
         scale = (g == 0) ? state.scale1 : state.scale2;
         for (int c = 0; c < 3; c++)
         begin
            next_state.duty[g * 3 + c] = 9'(state.cur[c] *
                                         (9'(scale[4 - 2 * c +: 2]) + 9'h001));
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state <= '0;
         state.ctrl <= CONTROL_RESET;
         state.scale1 <= SCALE_RESET;
         state.scale2 <= SCALE_RESET;
         state.cmd <= {16{COMMAND_RESET}};
         state.st <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign seq_busy = state.busy;

   // ==========================================================
   // Six channel drives
   logic [5:0] drive;

   for (genvar i = 0; i < 6; i++)
   begin : gen_pwm
      rgbps_pwm #(.WIDTH(9)) u_pwm (
         .mclk(mclk),
         .rst_b(rst_b),
         .count(state.pwm_cnt),
         .duty(state.duty[i]),
         .pwm_out(drive[i])
      );
   end

   assign group1_drive = {drive[0], drive[1], drive[2]};
   assign group2_drive = {drive[3], drive[4], drive[5]};

endmodule : rgbps_seq

`default_nettype wire

/* tb/rgbps_props.sv */
// Port checker for the RGB pattern sequencer
`timescale 1ns/10ps
`default_nettype none

module rgbps_props
   import rgbps_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port
   input wire rgbps_reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   // Drives
   input wire rgbps_rgb_type group1_drive,
   input wire rgbps_rgb_type group2_drive,
   input wire logic seq_busy
);
   // ==========================================================
   // Shadow of the writable bits
   logic [7:0] sh [256];
   logic [7:0] exp_q;
   logic [7:0] a;
   logic run;
   logic stop;
   assign a = reg_req.addr;
   assign run = sh[8'h11][2];
   assign stop = reg_req.wr && a == 8'h11 && !reg_req.wdata[2];

   function automatic logic [7:0] wm(input logic [7:0] x);
      return (x == 8'h11) ? 8'h07 : (x == 8'h12 || x == 8'h13) ? 8'h3f
         : (x[7:4] == 4'h4) ? 8'hff : 8'h00;
   endfunction : wm

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < 256; i++)
            sh[i] <= 8'h00;
         exp_q <= 8'h00;
      end
      else
      begin
         if (reg_req.rd)
            exp_q <= sh[a];
         if (reg_req.wr)
            sh[a] <= reg_req.wdata & wm(a);
      end
   end

   // ==========================================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_ctrl_readback: assert property (reg_req.rd && a == 8'h11 |=> reg_rdata == exp_q)
      else $error("control readback wrong");
   a_scale_readback: assert property (reg_req.rd && (a == 8'h12 || a == 8'h13)
      |=> reg_rdata == exp_q) else $error("scale readback wrong");
   a_slot_readback: assert property (reg_req.rd && a[7:4] == 4'h4 |=> reg_rdata == exp_q)
      else $error("command readback wrong");
   a_unmapped_zero: assert property (reg_req.rd && wm(a) == 8'h00 && a != 8'h14
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_stands: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved");
   a_start_busy: assert property (reg_req.wr && a == 8'h11 && reg_req.wdata[2] && !run
      && !seq_busy |-> ##3 seq_busy) else $error("start not seen");
   a_idle_no_run: assert property (!run && !seq_busy |=> !seq_busy)
      else $error("busy without run");
   a_stop_idle: assert property (stop |-> ##4 !seq_busy)
      else $error("stop not seen");
   a_stop_dark: assert property (stop |-> ##8 (group1_drive == 3'h0 && group2_drive == 3'h0))
      else $error("drives lit after stop");

   cover property (reg_req.wr && a == 8'h11 && reg_req.wdata[2]);
   cover property ($fell(seq_busy));
   cover property (reg_req.rd && a[7:4] == 4'h4);
endmodule : rgbps_props

bind rgbps_seq rgbps_props rgbps_props_i (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .group1_drive(group1_drive), .group2_drive(group2_drive),
   .seq_busy(seq_busy));
`default_nettype wire

/* tb/rgbps_led_model.sv */
// LED sink model: integrates each drive over one PWM frame
`timescale 1ns/10ps
`default_nettype none

module rgbps_led_model
   import rgbps_pkg::*;
(
   // Clock and frame restart
   input wire logic mclk,
   input wire logic clear,
   // Drives
   input wire rgbps_rgb_type group1_drive,
   input wire rgbps_rgb_type group2_drive,
   // Lit cycles, group 1 red first
   output logic [8:0] lit [6]
);
   logic [8:0] n;
   logic [5:0] on;
   assign on = {group1_drive, group2_drive};

   always_ff @(posedge mclk)
   begin
      if (clear)
      begin
         n <= 9'h000;
         lit <= '{default: 9'h000};
      end
      else if (n < PWM_PERIOD)
      begin
         n <= n + 9'h001;
         for (int k = 0; k < 6; k++)
            lit[k] <= lit[k] + 9'(on[5 - k]);
      end
   end
endmodule : rgbps_led_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking testbench for the RGB pattern sequencer
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import rgbps_pkg::*;
   // ==========================================================
   // Signals
   localparam int TL = 2;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   rgbps_reg_req_type reg_req = '0;
   logic [7:0] reg_rdata;
   rgbps_rgb_type group1_drive;
   rgbps_rgb_type group2_drive;
   logic seq_busy;
   logic clear = 1'b1;
   logic [8:0] lit [6];
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   logic [31:0] seed = 32'd77678;
   logic [7:0] st;
   logic [7:0] d;

   always #25 mclk = ~mclk;

   rgbps_seq #(.TICK_LEN(TL)) rgbps_seq_i (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .group1_drive(group1_drive), .group2_drive(group2_drive),
      .seq_busy(seq_busy));
   rgbps_led_model rgbps_led_model_i (.mclk(mclk), .clear(clear), .group1_drive(group1_drive),
      .group2_drive(group2_drive), .lit(lit));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [15:0] lvl(input logic [2:0] c, input logic cv, input logic [1:0] s);
      logic [6:0] t [2][8];
      t = '{'{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64},
            '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64}};
      return 16'(t[cv][c]) * (16'(s) + 16'h0001);
   endfunction : lvl

   function automatic logic [7:0] msk(input logic [7:0] a);
      return (a == 8'h12 || a == 8'h13) ? 8'h3f : (a[7:4] == 4'h4) ? 8'hff : 8'h00;
   endfunction : msk

   task automatic conclude();
      $display("Counts: %0d compares, %0d errors", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", n, exp, seen);
         err_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_req <= '{a, v, 1'b1, 1'b0};
      @(posedge mclk);
      reg_req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      reg_req.rd <= 1'b0;
      @(posedge mclk);
      #1 v = reg_rdata;
   endtask : rd

   // Integrate one full frame, then compare all six channels
   task automatic look(input logic [7:0] ca, cb, s1, s2, input logic cv);
      logic [2:0] c [3];
      c = '{ca[7:5], ca[4:2], cb[5:3]};
      @(posedge mclk);
      clear <= 1'b1;
      @(posedge mclk);
      clear <= 1'b0;
      repeat (PWM_PERIOD + 2) @(posedge mclk);
      #1;
      for (int k = 0; k < 3; k++)
      begin
         chk("group1 duty", lit[k], lvl(c[k], cv, s1[5 - 2 * k -: 2]));
         chk("group2 duty", lit[k + 3], lvl(c[k], cv, s2[5 - 2 * k -: 2]));
      end
   endtask : look

   // Start a pattern and time every slot change
   task automatic run(input logic lp);
      int t0;
      int df;
      logic [2:0] k;
      k = 3'h0;
      wr(8'h11, {5'h00, 1'b1, lp, 1'b0});
      // Start takes a store, an edge detect and a load cycle before the first slot counts
      t0 = cyc + 5;
      while (cyc < 90000)
      begin
         rd(8'h14, st);
         if (st[2:0] != k || st[6:4] == 3'h4)
         begin
            // One load cycle per slot; polling every third cycle blurs by two
            df = cyc - t0 - (HOLD_TIME_MS[k == 0 && !lp] + RAMP_TIME_MS[k == 1 && !lp]) * 10 * TL
               - 1;
            chk("slot time", 16'(df > -3 && df < 3), 16'h0001);
            if (st[6:4] == 3'h4 || k == 3'h7)
               break;
            chk("slot order", 16'(st[2:0]), 16'(k + 3'h1));
            k = st[2:0];
            t0 = cyc;
         end
      end
      chk("end state", 16'(lp ? st[3:0] : st[6:3]), 16'h0008);
   endtask : run

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count++;
         conclude();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      logic [31:0] r;
      logic [7:0] a;
      logic [7:0] ca;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd((i < 4) ? 8'h11 + 8'(i) : 8'h3c + 8'(i), d);
         chk("reset value", 16'(d), 16'h0000);
      end
      $display("Test reset done");
      wr(8'h11, 8'hfb);
      rd(8'h11, d);
      chk("control", 16'(d), 16'h0003);
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         a = r[1] ? {4'h4, r[7:4]} : r[0] ? 8'h12 + 8'(r[2]) : r[15:8];
         if (a == 8'h14 || a == 8'h11)
            a = 8'h20;
         wr(a, r[23:16]);
         rd(a, d);
         chk("readback", 16'(d), 16'(r[23:16] & msk(a)));
      end
      wr(8'h11, 8'h00);
      $display("Test registers done");
      for (int i = 0; i < 17; i++)
      begin
         r = rnd();
         ca = (i == 16) ? 8'hfc : {3'(i), r[4:0]};
         wr(8'h40, ca);
         wr(8'h41, (i == 16) ? 8'h38 : {r[15:10], 2'b00} & 8'hf8);
         wr(8'h12, (i == 16) ? 8'h3f : {2'b00, r[21:16]});
         wr(8'h13, (i == 16) ? 8'h3f : {2'b00, r[27:22]});
         wr(8'h11, {5'h00, 2'b10, i[3]});
         st = 8'h00;
         for (int j = 0; j < 40 && st[6:4] != 3'h3; j++)
            rd(8'h14, st);
         look(ca, (i == 16) ? 8'h38 : {r[15:10], 2'b00}, (i == 16) ? 8'h3f : {2'b00, r[21:16]},
            (i == 16) ? 8'h3f : {2'b00, r[27:22]}, i[3] && i != 16);
         wr(8'h11, 8'h00);
         repeat (10) @(posedge mclk);
      end
      $display("Test intensity done");
      for (int s = 0; s < 8; s++)
      begin
         wr(8'h40 + 8'(2 * s), {3'(s), ~3'(s), 2'b00});
         wr(8'h41 + 8'(2 * s), {1'b0, s == 0, 3'(s), 2'b00, s == 1});
      end
      run(1'b0);
      look(8'he0, 8'h38, 8'h3f, 8'h3f, 1'b0);
      wr(8'h11, 8'h00);
      wr(8'h41, 8'h00);
      wr(8'h43, 8'h08);
      $display("Test single pass done");
      run(1'b1);
      wr(8'h11, 8'h00);
      repeat (10) @(posedge mclk);
      rd(8'h14, st);
      chk("idle status", 16'(st), 16'h0000);
      chk("dark", 16'({group1_drive, group2_drive}), 16'h0000);
      $display("Test loop done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
